// ==== design/epp17_map.svh ====
`ifndef EPP17_MAP_SVH
`define EPP17_MAP_SVH

// Host I/O offsets from the port base
`define OFS_DATA        11'h000
`define OFS_STATUS      11'h001
`define OFS_CONTROL     11'h002
`define OFS_EPP_ADDR    11'h003
`define OFS_EPP_DATA0   11'h004
`define OFS_EPP_DATA3   11'h007
`define OFS_FIFO_VIEW   11'h400
`define OFS_CONFIG_B    11'h401
`define OFS_EXT_CTRL    11'h402

// Port control field positions
`define CTL_STROBE      0
`define CTL_AUTOFD      1
`define CTL_INIT        2
`define CTL_SELECT_IN   3
`define CTL_ACK_IRQ_EN  4
`define CTL_DIRECTION   5

// Port status field positions
`define STS_TIMEOUT     0

// Extended control field positions
`define ECR_EMPTY       0
`define ECR_FULL        1
`define ECR_SERVICE     2
`define ECR_DMA_EN      3
`define ECR_ERR_IRQ_N   4

// Reset values and the fixed config A readback value
`define CONTROL_RESET   6'h04
`define ECR_RESET       3'h5
`define CONFIG_A_VALUE  8'h10

// Timing
`define CLK_PERIOD_NS   10
`define EPP_TIMEOUT_NS  10000
`define EPP_TIMEOUT_CYC (`EPP_TIMEOUT_NS / `CLK_PERIOD_NS)

// Shared FIFO shape
`define FIFO_WIDTH      8
`define FIFO_DEPTH      16

`endif

// ==== design/epp17_pkg.sv ====
package epp17_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STROBE = 2'b01,
    ST_FWAIT  = 2'b10,
    ST_FINISH = 2'b11
  } cycle_state_t;

  typedef enum logic [2:0] {
    MODE_SPP    = 3'b000,
    MODE_BIDIR  = 3'b001,
    MODE_COMPAT_DATA_FIFO  = 3'b010,
    MODE_ECP    = 3'b011,
    MODE_EPP    = 3'b100,
    MODE_RSVD   = 3'b101,
    MODE_TEST   = 3'b110,
    MODE_CONFIG = 3'b111
  } port_mode_t;

  typedef logic [10:0] io_addr_t;
  typedef logic [7:0]  port_word_t;

endpackage : epp17_pkg

// ==== design/epp17_port.sv ====
// Functional notes
// - Write stretched while peripheral holds low
// - Read stretched while peripheral holds low
// - Write drives byte and asserts strobe on the same edge
// - Stretch ends on release or timeout
// - Write ends: ready, strobe off, byte kept
// - Direction one: write line off, bus released
// - Read strobe only with direction one; bus released unless control strobe set
// - Read ends: ready with sampled byte
// - Interrupt input passed through uninverted
// - Active-low peripheral reset output
// - Only write line overridden by control strobe
// - Port word is eight bits
// - All FIFO views share one 16-byte FIFO
// - Data, status, control reachable in all modes
// - Config B shows selected IRQ and DMA
// - Cycle aborted after ten microseconds
// - Timeout reported in status bit zero
// - Offset 3 address cycle, 4-7 data cycles
`timescale 1ns/1ps
`include "epp17_map.svh"

module epp17_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_full,
  output logic                  o_empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_full  = (count_reg == (AW+1)'(DEPTH));
  assign o_empty = (count_reg == '0);
  assign o_ready = !o_full;
  assign o_valid = !o_empty;
  assign o_data  = mem[rd_ptr_reg];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : epp17_fifo

module epp17_port (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Host I/O cycle port
  input  wire logic                 i_io_start,
  input  wire logic                 i_io_write,
  input  wire epp17_pkg::io_addr_t  i_io_addr,
  input  wire epp17_pkg::port_word_t i_io_wdata,
  output logic                      o_io_wait,
  output logic                      o_io_done,
  output logic                      o_io_timeout,
  output epp17_pkg::port_word_t     o_io_rdata,
  // Parallel port pins
  input  wire epp17_pkg::port_word_t i_port_bus,
  output epp17_pkg::port_word_t     o_port_bus,
  output logic                      o_port_bus_oe,
  output logic                      o_write_dir_n,
  output logic                      o_byte_strobe_n,
  output logic                      o_addr_strobe_n,
  output logic                      o_strobe_n,
  output logic                      o_autofd_n,
  output logic                      o_select_in_n,
  output logic                      o_periph_reset_n,
  input  wire logic                 i_periph_hold_n,
  input  wire logic                 i_busy,
  input  wire logic                 i_ack_n,
  input  wire logic                 i_paper_end,
  input  wire logic                 i_select,
  input  wire logic                 i_fault_in_n,
  input  wire logic                 i_port_irq_in,
  output logic                      o_port_irq,
  // Selections from the device configuration
  input  wire logic [2:0]           i_cfg_irq_sel,
  input  wire logic [2:0]           i_cfg_dma_sel,
  // Drain side of the shared FIFO
  output logic                      o_fifo_valid,
  input  wire logic                 i_fifo_ready,
  output epp17_pkg::port_word_t     o_fifo_data,
  output logic                      o_fifo_addr_tag
);
  import epp17_pkg::*;

  cycle_state_t state_reg;
  cycle_state_t state_next;
  port_mode_t   mode_reg;
  logic [5:0]   control_reg;
  logic [4:2]   ecr_bits_reg;
  port_word_t   port_data_byte_reg;
  port_word_t   rdata_reg;
  logic         timeout_flag_reg;
  logic         irq_reg;
  logic         is_addr_reg;
  logic         is_read_reg;
  logic [9:0]   timer_reg;
  logic         timeout_hit;
  logic         timeout_reg;
  port_word_t   wdata_reg;
  logic         addr_tag_reg;

  logic         take;
  logic         epp_access;
  logic         fifo_write_access;
  logic         fifo_read_access;
  logic         fifo_push;
  logic         fifo_pop_host;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_drain_ready;
  logic [8:0]   fifo_out_data;
  logic         fifo_full;
  logic         fifo_empty;
  logic         fifo_flush;
  logic         port_direction_bit;
  logic         strobe_override;
  logic         in_cycle;
  port_word_t   status_view;
  port_word_t   simple_rdata;

  assign take       = (state_reg == ST_IDLE) && i_io_start;
  assign in_cycle   = (state_reg == ST_STROBE);
  assign epp_access = (mode_reg == MODE_EPP) && (i_io_addr >= `OFS_EPP_ADDR)
                      && (i_io_addr <= `OFS_EPP_DATA3);

  // Writes into the shared FIFO views; ECP mode has two of them
  assign fifo_write_access = i_io_write && (
    ((i_io_addr == `OFS_DATA) && (mode_reg == MODE_ECP)) ||
    ((i_io_addr == `OFS_FIFO_VIEW) && ((mode_reg == MODE_COMPAT_DATA_FIFO) ||
      (mode_reg == MODE_ECP) || (mode_reg == MODE_TEST))));
  assign fifo_read_access  = !i_io_write && (i_io_addr == `OFS_FIFO_VIEW) &&
                             ((mode_reg == MODE_ECP) || (mode_reg == MODE_TEST));

  assign port_direction_bit = control_reg[`CTL_DIRECTION];
  assign timeout_hit        = (timer_reg == 10'(`EPP_TIMEOUT_CYC - 1));

  // Control strobe may force write mode, but only during a cycle
  assign strobe_override = in_cycle && control_reg[`CTL_STROBE];

  always_comb begin
    status_view = {!i_busy, i_ack_n, i_paper_end, i_select, i_fault_in_n, 3'b000};
    status_view[`STS_TIMEOUT] = timeout_flag_reg;
  end

  // Register views that answer in one cycle
  always_comb begin
    simple_rdata = 8'h00;
    case (i_io_addr)
      `OFS_DATA:      simple_rdata = port_direction_bit ? i_port_bus : port_data_byte_reg;
      `OFS_STATUS:    simple_rdata = status_view;
      `OFS_CONTROL:   simple_rdata = {2'b00, control_reg};
      `OFS_FIFO_VIEW: begin
        if (mode_reg == MODE_CONFIG) begin
          simple_rdata = `CONFIG_A_VALUE;
        end else begin
          simple_rdata = fifo_out_data[7:0];
        end
      end
      `OFS_CONFIG_B:  simple_rdata = {1'b0, i_port_irq_in, i_cfg_irq_sel,
                                      i_cfg_dma_sel[2:0]};
      `OFS_EXT_CTRL:  simple_rdata = {mode_reg, ecr_bits_reg, fifo_full, fifo_empty};
      default:        simple_rdata = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_io_start) begin
          if (epp_access) begin
            // A read with the bus still driven never strobes
            if (i_io_write || port_direction_bit) begin
              state_next = ST_STROBE;
            end else begin
              state_next = ST_FINISH;
            end
          end else if (fifo_write_access && !fifo_in_ready) begin
            state_next = ST_FWAIT;
          end else begin
            state_next = ST_FINISH;
          end
        end
      end
      ST_STROBE: begin
        if (i_periph_hold_n || timeout_hit) begin
          state_next = ST_FINISH;
        end
      end
      ST_FWAIT: begin
        if (fifo_in_ready) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Cycle bookkeeping
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wdata_reg    <= 8'h00;
      is_addr_reg  <= 1'b0;
      is_read_reg  <= 1'b0;
      addr_tag_reg <= 1'b0;
    end else if (take) begin
      wdata_reg    <= i_io_wdata;
      is_addr_reg  <= (i_io_addr == `OFS_EPP_ADDR);
      is_read_reg  <= !i_io_write;
      addr_tag_reg <= (i_io_addr == `OFS_DATA);
    end
  end

  // Watchdog over the strobe phase
  always_ff @(posedge i_clk) begin
    if (i_rst || take) begin
      timer_reg <= '0;
    end else if (in_cycle && !timeout_hit) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timeout_reg <= 1'b0;
    end else if (take) begin
      timeout_reg <= 1'b0;
    end else if (in_cycle && !i_periph_hold_n && timeout_hit) begin
      timeout_reg <= 1'b1;
    end
  end

  // Sticky timeout flag, cleared by a status read; a new timeout wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timeout_flag_reg <= 1'b0;
    end else if (in_cycle && !i_periph_hold_n && timeout_hit) begin
      timeout_flag_reg <= 1'b1;
    end else if (take && !i_io_write && (i_io_addr == `OFS_STATUS)) begin
      timeout_flag_reg <= 1'b0;
    end
  end

  // Read data returned with the final ready
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (take && !i_io_write) begin
      rdata_reg <= epp_access ? i_port_bus : simple_rdata;
    end else if (in_cycle && is_read_reg && state_next == ST_FINISH) begin
      rdata_reg <= i_port_bus;
    end
  end

  // Byte on the port bus; an address or data write keeps it latched
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port_data_byte_reg <= 8'h00;
    end else if (take && i_io_write && (epp_access || i_io_addr == `OFS_DATA)) begin
      port_data_byte_reg <= i_io_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      control_reg <= `CONTROL_RESET;
    end else if (take && i_io_write && (i_io_addr == `OFS_CONTROL)) begin
      control_reg <= i_io_wdata[5:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg     <= MODE_SPP;
      ecr_bits_reg <= `ECR_RESET;
    end else if (take && i_io_write && (i_io_addr == `OFS_EXT_CTRL)) begin
      mode_reg     <= port_mode_t'(i_io_wdata[7:5]);
      ecr_bits_reg <= i_io_wdata[4:2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= i_port_irq_in && control_reg[`CTL_ACK_IRQ_EN];
    end
  end

  // Shared FIFO: host fills, drain port or test reads empty it
  assign fifo_flush = take && i_io_write && (i_io_addr == `OFS_EXT_CTRL) &&
                      (i_io_wdata[7:6] == 2'b00);
  assign fifo_push  = ((take && fifo_write_access) || (state_reg == ST_FWAIT));
  assign fifo_pop_host    = take && fifo_read_access;
  assign fifo_drain_ready = (mode_reg == MODE_TEST) ? fifo_pop_host : i_fifo_ready;

  epp17_fifo #(
    .WIDTH(`FIFO_WIDTH + 1),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_flush (fifo_flush),
    .i_valid (fifo_push),
    .o_ready (fifo_in_ready),
    .i_data  (take ? {i_io_addr == `OFS_DATA, i_io_wdata} : {addr_tag_reg, wdata_reg}),
    .o_valid (fifo_out_valid),
    .i_ready (fifo_drain_ready),
    .o_data  (fifo_out_data),
    .o_full  (fifo_full),
    .o_empty (fifo_empty)
  );

  assign o_fifo_valid    = fifo_out_valid && (mode_reg != MODE_TEST);
  assign o_fifo_data     = fifo_out_data[7:0];
  assign o_fifo_addr_tag = fifo_out_data[8];

  // Host side answer
  assign o_io_wait    = (state_reg == ST_STROBE) || (state_reg == ST_FWAIT);
  assign o_io_done    = (state_reg == ST_FINISH);
  assign o_io_timeout = o_io_done && timeout_reg;
  assign o_io_rdata   = rdata_reg;

  // Pins
  assign o_write_dir_n   = port_direction_bit && !strobe_override;
  assign o_port_bus_oe   = !o_write_dir_n;
  assign o_port_bus      = port_data_byte_reg;
  assign o_byte_strobe_n = !(in_cycle && !is_addr_reg);
  assign o_addr_strobe_n = !(in_cycle && is_addr_reg);
  assign o_strobe_n      = !control_reg[`CTL_STROBE];
  assign o_autofd_n      = !control_reg[`CTL_AUTOFD];
  assign o_select_in_n   = !control_reg[`CTL_SELECT_IN];
  assign o_periph_reset_n = control_reg[`CTL_INIT];
  assign o_port_irq      = irq_reg;
endmodule : epp17_port

// ==== sim/epp17_periph.sv ====
`timescale 1ns/1ps

module epp17_periph (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_byte_strobe_n,
  input  wire logic       i_addr_strobe_n,
  input  wire logic       i_write_dir_n,
  input  wire logic [7:0] i_bus,
  input  wire logic [7:0] i_rd_byte,
  input  wire integer     i_delay,
  output logic      [7:0] o_bus,
  output logic            o_hold_n,
  output logic      [7:0] o_got,
  output logic            o_got_addr
);
  int  cnt;
  wire strb = !(i_byte_strobe_n && i_addr_strobe_n);

  always_ff @(posedge i_clk) begin
    if (i_rst || !strb) begin
      cnt      <= 0;
      // Ready for the next transfer; bus left floating shows a toggling pattern
      o_hold_n <= 1'b0;
      o_bus    <= i_rst ? 8'h00 : ~o_bus;
    end else begin
      cnt <= cnt + 1;
      if (i_write_dir_n) begin
        o_bus <= i_rd_byte;
      end
      // Release only after the byte has stood one edge on the bus
      if (cnt > i_delay) begin
        o_hold_n <= 1'b1;
        if (!i_write_dir_n) begin
          o_got      <= i_bus;
          o_got_addr <= !i_addr_strobe_n;
        end
      end
    end
  end
endmodule : epp17_periph

// ==== sim/epp17_port_sva.sv ====
`timescale 1ns/1ps
`include "epp17_map.svh"

module epp17_port_chk
  import epp17_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       o_io_wait,
  input wire logic       o_io_done,
  input wire logic       o_io_timeout,
  input wire port_word_t o_port_bus,
  input wire logic       o_port_bus_oe,
  input wire logic       o_write_dir_n,
  input wire logic       o_byte_strobe_n,
  input wire logic       o_addr_strobe_n,
  input wire logic       i_periph_hold_n,
  input wire logic       i_port_irq_in,
  input wire logic       o_port_irq
);
  int  strb_cnt;
  wire strb = !(o_byte_strobe_n && o_addr_strobe_n);

  always_ff @(posedge i_clk) begin
    if (i_rst || !strb) begin
      strb_cnt <= 0;
    end else begin
      strb_cnt <= strb_cnt + 1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_held;
    strb && !i_periph_hold_n;
  endsequence
  sequence s_released;
    strb && i_periph_hold_n;
  endsequence
  sequence s_end_ok;
    o_io_done && !o_io_timeout && o_byte_strobe_n && o_addr_strobe_n;
  endsequence

  a_idle_strobes_off: assert property (!o_io_wait |-> !strb)
    else $error("strobe low outside a cycle");
  a_one_strobe: assert property (!(!o_byte_strobe_n && !o_addr_strobe_n))
    else $error("both strobes low");
  a_read_bus_off: assert property (strb && o_write_dir_n |-> !o_port_bus_oe)
    else $error("bus driven during read strobe");
  a_write_bus_on: assert property (strb && !o_write_dir_n |-> o_port_bus_oe)
    else $error("bus not driven during write strobe");
  a_hold_stretch: assert property (s_held |=> o_io_wait || o_io_timeout)
    else $error("cycle ended while hold low");
  a_release_ends: assert property (s_released |=> s_end_ok)
    else $error("cycle did not end after release");
  a_byte_kept: assert property (strb && !o_write_dir_n |=> $stable(o_port_bus))
    else $error("written byte changed");
  a_timeout_cap: assert property (strb |-> strb_cnt < `EPP_TIMEOUT_CYC)
    else $error("strobe phase too long");
  a_timeout_done: assert property (o_io_timeout |-> o_io_done && $past(strb))
    else $error("timeout without aborted cycle");
  a_done_pulse: assert property (o_io_done |=> !o_io_done)
    else $error("done longer than one cycle");
  a_irq_pass: assert property (o_port_irq |-> $past(i_port_irq_in))
    else $error("irq without input");
endmodule : epp17_port_chk

// ==== sim/epp17_port_tb.sv ====
`timescale 1ns/1ps
`include "epp17_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end

module epp17_port_tb;
  import epp17_pkg::*;
  logic       i_clk, i_rst, i_io_start, i_io_write, i_fifo_ready, i_irq, tmo, got_addr;
  logic       o_io_wait, o_io_done, o_io_timeout, o_port_bus_oe, o_write_dir_n;
  logic       o_byte_strobe_n, o_addr_strobe_n, o_periph_reset_n, o_port_irq, hold_n;
  logic       o_fifo_valid, o_fifo_addr_tag;
  logic       o_strobe_n, o_autofd_n, o_select_in_n;
  logic [2:0] cfg_irq, cfg_dma;
  logic [4:0] st;
  io_addr_t   i_io_addr;
  port_word_t i_io_wdata, o_io_rdata, o_port_bus, periph_bus, got_byte, rd_byte, rd;
  port_word_t o_fifo_data;
  int         errors, total_checks, dly, k;
  wire port_word_t i_port_bus = o_port_bus_oe ? o_port_bus : periph_bus;

  epp17_port epp17_port_i (.i_clk(i_clk), .i_rst(i_rst), .i_io_start(i_io_start),
    .i_io_write(i_io_write), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata),
    .o_io_wait(o_io_wait), .o_io_done(o_io_done), .o_io_timeout(o_io_timeout),
    .o_io_rdata(o_io_rdata), .i_port_bus(i_port_bus), .o_port_bus(o_port_bus),
    .o_port_bus_oe(o_port_bus_oe), .o_write_dir_n(o_write_dir_n),
    .o_byte_strobe_n(o_byte_strobe_n), .o_addr_strobe_n(o_addr_strobe_n),
    .o_strobe_n(o_strobe_n), .o_autofd_n(o_autofd_n), .o_select_in_n(o_select_in_n),
    .o_periph_reset_n(o_periph_reset_n),
    .i_periph_hold_n(hold_n), .i_busy(st[4]), .i_ack_n(st[3]), .i_paper_end(st[2]),
    .i_select(st[1]), .i_fault_in_n(st[0]), .i_port_irq_in(i_irq), .o_port_irq(o_port_irq),
    .i_cfg_irq_sel(cfg_irq), .i_cfg_dma_sel(cfg_dma), .o_fifo_valid(o_fifo_valid),
    .i_fifo_ready(i_fifo_ready), .o_fifo_data(o_fifo_data), .o_fifo_addr_tag(o_fifo_addr_tag));

  epp17_periph epp17_periph_i (.i_clk(i_clk), .i_rst(i_rst), .i_byte_strobe_n(o_byte_strobe_n),
    .i_addr_strobe_n(o_addr_strobe_n), .i_write_dir_n(o_write_dir_n), .i_bus(i_port_bus),
    .i_rd_byte(rd_byte), .i_delay(dly), .o_bus(periph_bus), .o_hold_n(hold_n),
    .o_got(got_byte), .o_got_addr(got_addr));

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic io(input logic w, input io_addr_t a, input port_word_t d,
                    output port_word_t r);
    int n;
    @(negedge i_clk);
    i_io_start = 1'b1;
    i_io_write = w;
    i_io_addr  = a;
    i_io_wdata = d;
    for (n = 0; n < 1200; n++) begin
      @(negedge i_clk);
      i_io_start = 1'b0;
      if (o_io_done === 1'b1) break;
    end
    r   = o_io_rdata;
    tmo = o_io_timeout;
    if (n == 1200) begin
      errors++;
      final_report();
    end
  endtask : io

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    {i_io_start, i_io_write, i_fifo_ready, i_irq} = 4'h0;
    i_io_addr = 11'h000;
    i_io_wdata = 8'h00;
    rd_byte = 8'h5C;
    dly = 0;
    st = 5'b10101;
    cfg_irq = 3'h5;
    cfg_dma = 3'h2;
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    io(0, `OFS_CONTROL, 8'h00, rd);   `CHK(rd, 8'h04)
    io(0, `OFS_EXT_CTRL, 8'h00, rd);  `CHK(rd, 8'h15)
    io(0, `OFS_CONFIG_B, 8'h00, rd);  `CHK(rd, 8'h2A)
    {cfg_irq, cfg_dma, i_irq} = 7'h3D;
    io(0, `OFS_CONFIG_B, 8'h00, rd);  `CHK(rd, 8'h5E)
    i_irq = 1'b0;
    io(0, 11'h3FF, 8'h00, rd);        `CHK(rd, 8'h00)
    io(0, `OFS_STATUS, 8'h00, rd);    `CHK(rd, 8'h28)
    io(1, `OFS_EXT_CTRL, 8'h95, rd);
    st = 5'b01010;
    io(0, `OFS_STATUS, 8'h00, rd);    `CHK(rd, 8'hD0)
    io(1, `OFS_CONTROL, 8'h04, rd);
    for (k = 3; k < 8; k++) begin
      dly = k - 3;
      io(1, k[10:0], 8'hA0 + k[7:0], rd);
      `CHK(tmo, 1'b0)
      `CHK(got_byte, 8'hA0 + k[7:0])
      `CHK(got_addr, k == 3)
      `CHK(o_port_bus, 8'hA0 + k[7:0])
    end
    io(1, `OFS_CONTROL, 8'h24, rd);
    `CHK(o_write_dir_n, 1'b1)
    `CHK(o_port_bus_oe, 1'b0)
    dly = 2;
    io(0, `OFS_EPP_DATA0, 8'h00, rd); `CHK(rd, 8'h5C)
    dly = 1500;
    io(0, `OFS_EPP_DATA3, 8'h00, rd); `CHK(tmo, 1'b1)
    io(0, `OFS_STATUS, 8'h00, rd);    `CHK(rd[0], 1'b1)
    io(0, `OFS_STATUS, 8'h00, rd);    `CHK(rd[0], 1'b0)
    dly = 0;
    // Control strobe set during a read forces write mode, so the bus shows the latched byte
    io(1, `OFS_CONTROL, 8'h21, rd);
    io(0, `OFS_EPP_DATA0, 8'h00, rd); `CHK(rd, 8'hA7)
    `CHK(o_write_dir_n, 1'b1)
    io(1, `OFS_CONTROL, 8'h1B, rd);
    `CHK({o_strobe_n, o_autofd_n, o_select_in_n}, 3'h0)
    i_irq = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK(o_port_irq, 1'b1)
    `CHK(o_periph_reset_n, 1'b0)
    i_irq = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK(o_port_irq, 1'b0)
    io(1, `OFS_CONTROL, 8'h04, rd);
    io(1, `OFS_EXT_CTRL, 8'h75, rd);
    for (k = 0; k < 16; k++) begin
      io(1, (k < 8) ? `OFS_DATA : `OFS_FIFO_VIEW, 8'h30 + k[7:0], rd);
    end
    io(0, `OFS_EXT_CTRL, 8'h00, rd);  `CHK(rd[1:0], 2'b10)
    i_fifo_ready = 1'b1;
    for (k = 0; k < 16; k++) begin
      `CHK(o_fifo_valid, 1'b1)
      `CHK(o_fifo_data, 8'h30 + k[7:0])
      `CHK(o_fifo_addr_tag, k < 8)
      @(negedge i_clk);
    end
    i_fifo_ready = 1'b0;
    `CHK(o_fifo_valid, 1'b0)
    io(0, `OFS_EXT_CTRL, 8'h00, rd);  `CHK(rd[1:0], 2'b01)
    final_report();
  end
endmodule : epp17_port_tb

bind epp17_port epp17_port_chk epp17_port_chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .o_io_wait(o_io_wait), .o_io_done(o_io_done), .o_io_timeout(o_io_timeout),
  .o_port_bus(o_port_bus), .o_port_bus_oe(o_port_bus_oe), .o_write_dir_n(o_write_dir_n),
  .o_byte_strobe_n(o_byte_strobe_n), .o_addr_strobe_n(o_addr_strobe_n),
  .i_periph_hold_n(i_periph_hold_n), .i_port_irq_in(i_port_irq_in), .o_port_irq(o_port_irq));
